//--- design/sebr_pkg.sv
// Package for the serial error, burst and software reset register block.
// Assumes a byte-wide register map reached over a four-wire serial link.
package sebr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register addresses as carried in the seven-bit address field.
   localparam logic [6:0] ADDR_SW = 7'h01;
   localparam logic [6:0] ADDR_CFG = 7'h02;
   localparam logic [6:0] ADDR_ERR = 7'h03;
   localparam logic [6:0] ADDR_BURST = 7'h05;
   localparam logic [6:0] ADDR_KEY = 7'h0b;

   ////////////////////////////////////////////////////////////////////////
   // Reset values of the stored fields.
   localparam logic [3:0] SW_RST = 4'h0;
   localparam logic [2:0] CFG_RST = 3'h6;
   localparam logic [2:0] ERR_RST = 3'h0;
   localparam logic BURST_RST = 1'b0;
   localparam logic [7:0] KEY_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Bit positions inside the error enable and error status fields, the burst field and the command word.
   localparam int unsigned BIT_ADDR = 2;
   localparam int unsigned BIT_CNT = 1;
   localparam int unsigned BIT_CRC = 0;
   localparam int unsigned BIT_BURST = 0;
   localparam int unsigned BIT_RW = 15;

   ////////////////////////////////////////////////////////////////////////
   // Command words, key values and frame lengths in serial clocks.
   localparam logic [15:0] CLEAR_CMD = 16'h6ca9;
   localparam logic [7:0] KEY_FIRST = 8'ha3;
   localparam logic [7:0] KEY_SECOND = 8'h05;
   localparam logic [4:0] LEN_PLAIN = 5'h10;
   localparam logic [4:0] LEN_CRC = 5'h18;

   ////////////////////////////////////////////////////////////////////////
   // Check byte generator over the sixteen command bits.
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Software reset key sequence states.
   typedef enum logic [1:0] {
      KEY_IDLE = 2'b01,
      KEY_ARMED = 2'b10
   } sebr_key_type;

endpackage

//--- design/sebr_regs.sv
// Error flags, burst enable and software reset registers behind a serial port.
// Assumes sclk is stopped while cs_n is high and that clk runs freely.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: Command 0x6ca9 clears all error flags.
// R2: Clear command never raises address error.
// R3: With check byte on, clear needs good byte.
// R4: Read of missing address sets bit 2.
// R5: Write to missing or read-only sets bit 2.
// R6: Wrong serial clock count sets bit 1.
// R7: Failed check byte on write sets bit 0.
// R8: Flags read one on error, reset zero.
// R9: Status bits 7 to 3 read zero.
// R10: Burst bit allows several commands per select.
// R11: Key 0xa3 then 0x05 restores defaults.
// R12: Host writes zeros to burst bits 7:1.
// R13: Expect 16 or 24 clocks, multiples in burst.
// R14: Check byte on means 24-bit frames.
// R15: Each check gated by its enable bit.
// R16: Flags stay set until clear or reset.
// R17: Any other write between keys cancels; here refused writes, the clear command and a repeated 0xa3 leave the key armed.
module sebr_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic [3:0] sw_en
);

   ////////////////////////////////////////////////////////////////////////
   // Serial clock domain state.
   logic frame_rst_n, fs_r, ftog_r, ftog_nxt, tog_r, tog_nxt, done, take, sdo_r, sdo_nxt;
   logic crc_s1_r, crc_s2_r, bst_s1_r, bst_s2_r;
   logic [4:0] pos_r, pos_nxt, pos_cur, len;
   logic [1:0] ncmd_r, ncmd_nxt, ncmd_cur;
   logic [23:0] sh_r, sh_nxt, cmd_r, cmd_nxt;

   // Clock domain state.
   logic cs1_r, cs2_r, cs3_r, t1_r, t2_r, t3_r, f1_r, f2_r, fseen_r, fseen_nxt;
   logic burst_r, burst_nxt, cmd_ev, frame_end, clocked;
   logic crc_en, crc_ok, is_rd, is_clear, rd_ok, wr_ok, wr_ev, key_wr, srst, clr;
   logic [2:0] cfg_r, cfg_nxt, err_r, err_nxt, set;
   logic [3:0] sw_r, sw_nxt;
   logic [7:0] key_r, key_nxt, rsp_r, rsp_nxt, wdata, rdata;
   sebr_pkg::sebr_key_type kst_r, kst_nxt;
   logic [15:0] word;
   logic [6:0] addr;

   // Check byte over the command bits, most significant bit first.
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = sebr_pkg::CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? sebr_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Frame start flag, cleared while select is high so the first edge of
   // every frame restarts the bit position.
   assign frame_rst_n = nrst & ~cs_n;
   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         fs_r <= 1'b0;
      end else begin
         fs_r <= 1'b1;
      end
   end

   // Shift, bit count and command capture on the rising serial clock.
   always_comb begin
      len = crc_s2_r ? sebr_pkg::LEN_CRC : sebr_pkg::LEN_PLAIN; // see R14
      pos_cur = fs_r ? pos_r : 5'h00;
      ncmd_cur = fs_r ? ncmd_r : 2'h0;
      sh_nxt = {sh_r[22:0], sdi};
      done = (5'(pos_cur + 5'h01) == len); // see R13
      pos_nxt = done ? 5'h00 : 5'(pos_cur + 5'h01);
      ncmd_nxt = (done && ncmd_cur != 2'h3) ? 2'(ncmd_cur + 2'h1) : ncmd_cur;
      take = done && (ncmd_cur == 2'h0 || bst_s2_r); // see R10
      tog_nxt = tog_r ^ take;
      cmd_nxt = take ? sh_nxt : cmd_r;
      ftog_nxt = ftog_r ^ ~fs_r;
   end
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         pos_r <= 5'h00;
         ncmd_r <= 2'h0;
         sh_r <= 24'h000000;
         cmd_r <= 24'h000000;
         tog_r <= 1'b0;
         ftog_r <= 1'b0;
         crc_s1_r <= 1'b0;
         crc_s2_r <= 1'b0;
         bst_s1_r <= 1'b0;
         bst_s2_r <= 1'b0;
      end else begin
         pos_r <= pos_nxt;
         ncmd_r <= ncmd_nxt;
         sh_r <= sh_nxt;
         cmd_r <= cmd_nxt;
         tog_r <= tog_nxt;
         ftog_r <= ftog_nxt;
         crc_s1_r <= cfg_r[sebr_pkg::BIT_CRC];
         crc_s2_r <= crc_s1_r;
         bst_s1_r <= burst_r;
         bst_s2_r <= bst_s1_r;
      end
   end

   // Read data leaves on the falling edge in the second byte of a frame.
   always_comb begin
      sdo_nxt = 1'b0;
      if (pos_r[4:3] == 2'b01) begin
         sdo_nxt = rsp_r[3'(~pos_r[2:0])];
      end
   end
   always_ff @(negedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         sdo_r <= 1'b0;
      end else begin
         sdo_r <= sdo_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for select, command toggle and frame start toggle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs1_r <= 1'b1;
         cs2_r <= 1'b1;
         cs3_r <= 1'b1;
         t1_r <= 1'b0;
         t2_r <= 1'b0;
         t3_r <= 1'b0;
         f1_r <= 1'b0;
         f2_r <= 1'b0;
      end else begin
         cs1_r <= cs_n;
         cs2_r <= cs1_r;
         cs3_r <= cs2_r;
         t1_r <= tog_r;
         t2_r <= t1_r;
         t3_r <= t2_r;
         f1_r <= ftog_r;
         f2_r <= f1_r;
      end
   end

   // Command decode; count and word are stable once the event is seen.
   always_comb begin
      cmd_ev = t2_r ^ t3_r;
      frame_end = cs2_r & ~cs3_r;
      clocked = f2_r ^ fseen_r;
      crc_en = cfg_r[sebr_pkg::BIT_CRC];
      word = crc_en ? cmd_r[23:8] : cmd_r[15:0];
      crc_ok = !crc_en || (crc8(cmd_r[23:8]) == cmd_r[7:0]);
      is_rd = word[sebr_pkg::BIT_RW];
      addr = word[14:8];
      wdata = word[7:0];
      is_clear = (word == sebr_pkg::CLEAR_CMD);
      rd_ok = addr == sebr_pkg::ADDR_SW || addr == sebr_pkg::ADDR_CFG ||
              addr == sebr_pkg::ADDR_ERR || addr == sebr_pkg::ADDR_BURST ||
              addr == sebr_pkg::ADDR_KEY;
      wr_ok = rd_ok && addr != sebr_pkg::ADDR_ERR;
      wr_ev = cmd_ev && crc_ok && !is_rd && !is_clear && wr_ok;
      key_wr = wr_ev && addr == sebr_pkg::ADDR_KEY;
   end

   // Read multiplexer; unused upper bits read as zero.
   always_comb begin
      case (addr)
         sebr_pkg::ADDR_SW: rdata = {4'h0, sw_r};
         sebr_pkg::ADDR_CFG: rdata = {5'h00, cfg_r};
         sebr_pkg::ADDR_ERR: rdata = {5'h00, err_r}; // see R9
         sebr_pkg::ADDR_BURST: rdata = {7'h00, burst_r};
         sebr_pkg::ADDR_KEY: rdata = key_r;
         default: rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register updates, error detection and the key sequence.
   always_comb begin
      sw_nxt = sw_r;
      cfg_nxt = cfg_r;
      burst_nxt = burst_r;
      key_nxt = key_r;
      kst_nxt = kst_r;
      rsp_nxt = rsp_r;
      fseen_nxt = frame_end ? f2_r : fseen_r;
      set = 3'h0;
      clr = 1'b0;
      srst = 1'b0;
      if (cmd_ev) begin
         if (!crc_ok) begin
            set[sebr_pkg::BIT_CRC] = !is_rd && cfg_r[sebr_pkg::BIT_CRC]; // see R7
         end else if (is_clear) begin
            clr = 1'b1; // see R1, R2, R3
         end else if (is_rd) begin
            rsp_nxt = rdata;
            set[sebr_pkg::BIT_ADDR] = !rd_ok && cfg_r[sebr_pkg::BIT_ADDR]; // see R4, R15
         end else begin
            set[sebr_pkg::BIT_ADDR] = !wr_ok && cfg_r[sebr_pkg::BIT_ADDR]; // see R5, R15
         end
      end
      if (frame_end && clocked && cfg_r[sebr_pkg::BIT_CNT]) begin
         // A bad remainder or several commands without burst is a count fault.
         set[sebr_pkg::BIT_CNT] = pos_r != 5'h00 || (ncmd_r != 2'h1 && !burst_r); // see R6, R13, R15
      end
      if (wr_ev) begin
         case (addr)
            sebr_pkg::ADDR_SW: sw_nxt = wdata[3:0];
            sebr_pkg::ADDR_CFG: cfg_nxt = wdata[2:0];
            sebr_pkg::ADDR_BURST: burst_nxt = wdata[sebr_pkg::BIT_BURST]; // see R10, R12
            sebr_pkg::ADDR_KEY: key_nxt = wdata;
            default: sw_nxt = sw_r;
         endcase
         kst_nxt = sebr_pkg::KEY_IDLE; // see R17
         case (kst_r)
            sebr_pkg::KEY_IDLE: begin
               if (key_wr && wdata == sebr_pkg::KEY_FIRST) begin
                  kst_nxt = sebr_pkg::KEY_ARMED;
               end
            end
            sebr_pkg::KEY_ARMED: begin
               if (key_wr && wdata == sebr_pkg::KEY_SECOND) begin
                  srst = 1'b1; // see R11
               end else if (key_wr && wdata == sebr_pkg::KEY_FIRST) begin
                  kst_nxt = sebr_pkg::KEY_ARMED;
               end
            end
            default: kst_nxt = sebr_pkg::KEY_IDLE;
         endcase
      end
      // A new error wins over a clear in the same cycle.
      err_nxt = (err_r & ~{3{clr}}) | set; // see R8, R16
      if (srst) begin
         sw_nxt = sebr_pkg::SW_RST;
         cfg_nxt = sebr_pkg::CFG_RST;
         burst_nxt = sebr_pkg::BURST_RST;
         key_nxt = sebr_pkg::KEY_RST;
         err_nxt = sebr_pkg::ERR_RST;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sw_r <= sebr_pkg::SW_RST;
         cfg_r <= sebr_pkg::CFG_RST;
         burst_r <= sebr_pkg::BURST_RST;
         key_r <= sebr_pkg::KEY_RST;
         kst_r <= sebr_pkg::KEY_IDLE;
         err_r <= sebr_pkg::ERR_RST;
         rsp_r <= 8'h00;
         fseen_r <= 1'b0;
      end else begin
         sw_r <= sw_nxt;
         cfg_r <= cfg_nxt;
         burst_r <= burst_nxt;
         key_r <= key_nxt;
         kst_r <= kst_nxt;
         err_r <= err_nxt;
         rsp_r <= rsp_nxt;
         fseen_r <= fseen_nxt;
      end
   end

   // Outputs come straight from flip-flops.
   assign sdo = sdo_r;
   assign sw_en = sw_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the clear command, error detection, the status read and the sticky flags.
   AST_CLEAR: assert property ( // see R1
      @(posedge clk) disable iff (!nrst)
      cmd_ev && is_clear && crc_ok && !frame_end |=> err_r == 3'h0)
      else $error("Clear command left a flag set.");
   AST_CLEAR_NO_ADDR: assert property ( // see R2
      @(posedge clk) disable iff (!nrst)
      cmd_ev && is_clear |=> !$rose(err_r[2]))
      else $error("Clear command raised the address flag.");
   // A refused clear must leave every flag that was already set.
   AST_CLEAR_NEEDS_CRC: assert property ( // see R3
      @(posedge clk) disable iff (!nrst)
      cmd_ev && is_clear && !crc_ok |=> (err_r & $past(err_r)) == $past(err_r))
      else $error("Clear with bad check byte took effect.");
   AST_READ_ADDR: assert property ( // see R4
      @(posedge clk) disable iff (!nrst)
      cmd_ev && crc_ok && is_rd && !rd_ok && cfg_r[2] |=> err_r[2])
      else $error("Read of missing address not flagged.");
   AST_WRITE_ADDR: assert property ( // see R5
      @(posedge clk) disable iff (!nrst)
      cmd_ev && crc_ok && !is_rd && !is_clear && !wr_ok && cfg_r[2] |=> err_r[2])
      else $error("Bad write address not flagged.");
   AST_COUNT: assert property ( // see R6
      @(posedge clk) disable iff (!nrst)
      frame_end && clocked && cfg_r[1] && pos_r != 5'h00 |=> err_r[1])
      else $error("Clock count fault not flagged.");
   AST_CRC: assert property ( // see R7
      @(posedge clk) disable iff (!nrst)
      cmd_ev && cfg_r[0] && !crc_ok && !is_rd |=> err_r[0])
      else $error("Check byte fault not flagged.");
   AST_STATUS_READ: assert property ( // see R9
      @(posedge clk) disable iff (!nrst)
      cmd_ev && crc_ok && is_rd && addr == sebr_pkg::ADDR_ERR
      |=> rsp_r == {5'h00, $past(err_r)})
      else $error("Status read returned wrong bits.");
   AST_STICKY: assert property ( // see R16
      @(posedge clk) disable iff (!nrst)
      !clr && !srst |=> (err_r & $past(err_r)) == $past(err_r))
      else $error("A flag dropped without a clear.");

   // Key sequence steps.
   sequence s_armed;
      kst_r == sebr_pkg::KEY_ARMED;
   endsequence
   sequence s_second;
      key_wr && wdata == sebr_pkg::KEY_SECOND;
   endsequence
   AST_SOFT_RESET: assert property ( // see R11
      @(posedge clk) disable iff (!nrst)
      s_armed and s_second |=> cfg_r == sebr_pkg::CFG_RST && !burst_r && err_r == 3'h0)
      else $error("Key sequence did not restore defaults.");
   AST_KEY_CANCEL: assert property ( // see R17
      @(posedge clk) disable iff (!nrst)
      wr_ev && !key_wr |=> kst_r == sebr_pkg::KEY_IDLE)
      else $error("Other write did not cancel the key.");
   AST_NO_BURST: assert property ( // see R10
      @(posedge sclk) disable iff (!nrst)
      done && ncmd_cur != 2'h0 && !bst_s2_r |=> tog_r == $past(tog_r))
      else $error("Second command taken without burst.");

endmodule

`default_nettype wire

//--- testbench/sebr_host_model.sv
// Serial host model that frames commands for the register block.
// Assumes mode 0 timing; the 125 ns serial clock runs only inside frames.
`timescale 1ns/1ps
`default_nettype none

module sebr_host_model (
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);

   ////////////////////////////////////////////////////////////////////////
   // Idle state: select high and serial clock parked low.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sends nbits from the top of bits and returns the bits seen in slots 8 to 15.
   task automatic xfer(input int nbits, input logic [47:0] bits, output logic [7:0] rdata);
      rdata = 8'h00;
      #17 cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi = bits[47 - i];
         #62.5 sclk = 1'b1;
         if (i >= 8 && i < 16) begin
            rdata = {rdata[6:0], sdo};
         end
         #62.5 sclk = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      // The released data line flips so a stale level cannot pass for a driven one.
      sdi = ~sdi;
   endtask

endmodule

`default_nettype wire

//--- testbench/sebr_regs_tb.sv
// Self-checking bench for the error, burst and software reset registers.
// Assumes the host model owns the serial pins and the bench owns clk and nrst.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module sebr_regs_tb;

   typedef struct {logic [15:0] w; logic [6:0] a; logic [7:0] e;} sebr_row_type;

   logic clk;
   logic nrst;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic [3:0] sw_en;
   logic crc_on;
   logic [7:0] rd;
   int fails;
   int cmp_count;
   sebr_row_type rows [10];

   sebr_regs sebr_regs_i (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sw_en(sw_en));
   sebr_host_model sebr_host_model_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   ////////////////////////////////////////////////////////////////////////
   // System clock at 20 MHz.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Check byte over a command word, MSB first.
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = sebr_pkg::CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ sebr_pkg::CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   // One frame of n clocks, then a gap long enough for the register update.
   task automatic raw(input int n, input logic [47:0] b);
      sebr_host_model_i.xfer(n, b, rd);
      repeat (10) @(posedge clk);
   endtask

   // One command, framed as the current check byte setting needs.
   task automatic send(input logic [15:0] w);
      if (crc_on) raw(24, {w, crc8(w), 24'h000000});
      else raw(16, {w, 32'h00000000});
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      send({1'b0, a, d});
   endtask

   // Read data returns in the slot after the read command.
   task automatic rdreg(input logic [6:0] a);
      send({1'b1, a, 8'h00});
      send({1'b1, a, 8'h00});
   endtask

   task automatic summarize();
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Bound on the whole run.
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////
   // Table of ordinary cases, then hand-written awkward cases.
   initial begin
      nrst = 1'b0;
      crc_on = 1'b0;
      fails = 0;
      cmp_count = 0;
      rows = '{'{16'h8300, 7'h03, 8'h00}, '{16'h8200, 7'h02, 8'h06}, '{16'h8500, 7'h05, 8'h00},
               '{16'h8b00, 7'h0b, 8'h00}, '{16'hff00, 7'h03, 8'h04}, '{sebr_pkg::CLEAR_CMD, 7'h03, 8'h00},
               '{16'h0300, 7'h03, 8'h04}, '{sebr_pkg::CLEAR_CMD, 7'h03, 8'h00}, '{16'h0a55, 7'h03, 8'h04},
               '{16'h0105, 7'h01, 8'h05}};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         send(rows[i].w);
         rdreg(rows[i].a);
         `CHK(rd, rows[i].e)
      end
      `CHK(sw_en, 4'h5)
      // Short and over-long frames without burst.
      send(sebr_pkg::CLEAR_CMD);
      raw(12, 48'h010600000000);
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h02)
      send(sebr_pkg::CLEAR_CMD);
      raw(32, 48'h010601090000);
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h02)
      `CHK(sw_en, 4'h6)
      // Checks switched off stay silent.
      wr(sebr_pkg::ADDR_CFG, 8'h00);
      send(sebr_pkg::CLEAR_CMD);
      send(16'hff00);
      raw(12, 48'h010600000000);
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h00)
      wr(sebr_pkg::ADDR_CFG, 8'h04);
      // Two commands in one select with burst on.
      wr(sebr_pkg::ADDR_BURST, 8'h01);
      raw(32, 48'h010905000000);
      `CHK(sw_en, 4'h9)
      rdreg(sebr_pkg::ADDR_BURST);
      `CHK(rd, 8'h00)
      // Interrupted key, then a full key sequence.
      send(16'hff00);
      wr(sebr_pkg::ADDR_KEY, 8'ha3);
      wr(sebr_pkg::ADDR_SW, 8'h01);
      wr(sebr_pkg::ADDR_KEY, 8'h05);
      `CHK(sw_en, 4'h1)
      wr(sebr_pkg::ADDR_KEY, 8'ha3);
      wr(sebr_pkg::ADDR_KEY, 8'h05);
      `CHK(sw_en, 4'h0)
      rdreg(sebr_pkg::ADDR_CFG);
      `CHK(rd, 8'h06)
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h00)
      // Check byte mode: bad write, bad clear, good clear, short frame.
      wr(sebr_pkg::ADDR_CFG, 8'h07);
      crc_on = 1'b1;
      raw(24, {16'h0102, crc8(16'h0102) ^ 8'hff, 24'h000000});
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h01)
      `CHK(sw_en, 4'h0)
      // A second flag that a bad clear would wipe and the write fault would not restore.
      send(16'hff00);
      raw(24, {sebr_pkg::CLEAR_CMD, crc8(sebr_pkg::CLEAR_CMD) ^ 8'h01, 24'h000000});
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h05)
      send(sebr_pkg::CLEAR_CMD);
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h00)
      raw(16, 48'h010200000000);
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h02)
      // Hardware reset in mid-run restores every default.
      wr(sebr_pkg::ADDR_SW, 8'h0c);
      `CHK(sw_en, 4'hc)
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(sw_en, 4'h0)
      nrst <= 1'b1;
      crc_on = 1'b0;
      repeat (3) @(posedge clk);
      rdreg(sebr_pkg::ADDR_ERR);
      `CHK(rd, 8'h00)
      summarize();
   end

endmodule

`undef CHK
`default_nettype wire
